/* logic/rwl_top.v */
// Register write lock: unlock key sequence and write gate
//
// Contract
// RULE1: Protection is engaged after reset until the full key is written.
// RULE2: Key is 59h, 16h, 88h as three consecutive lock register writes.
// RULE3: Wrong value, wrong order or another write abandons the key sequence.
// RULE4: Completed key sets the disabled flag and opens all guarded writes.
// RULE5: Lock register bit 0 reads one when unprotected, zero when protected.
// RULE6: Any write to the lock register while open relocks and clears flag.
// RULE7: Lock register low byte is write-only key; reads give only the flag.
// RULE8: Writes to guarded registers or bits are dropped while protected.
// RULE9: Peripheral reset, brown-out and power-on reset controls fully guarded.
// RULE10: Power control guarded except bit 6, the wake-up interrupt clear.
// RULE11: Peripheral clock enable register guards only bit 0.
// RULE12: Bus and tick clock source select register is fully guarded.
// RULE13: Second clock source select guards only bits 1 to 0.
// RULE14: NMI source select register guards only bit 8.
// RULE15: Flash programming control, trigger and timing registers fully guarded.
// RULE16: Watchdog control register is fully guarded.
// RULE17: After an abort, matching restarts; an aborting 59h starts anew.
//
// Local design decision: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "rwl_defines.vh"

module rwl_top
(
	input  wire        core_clk,
	input  wire        reset,
	input  wire        ce,
	input  wire [31:0] bus_addr,
	input  wire [31:0] bus_wdata,
	input  wire        bus_wr,
	input  wire        bus_rd,
	output reg  [31:0] bus_rdata,
	output reg         fwd_wr,
	output reg  [31:0] fwd_addr,
	output reg  [31:0] fwd_wdata,
	output reg  [31:0] fwd_wmask,
	output reg         fwd_rd,
	output reg  [31:0] fwd_raddr,
	output wire        protect_disabled_flag,
	output reg         key_abort
);

	// ------------------------------------------------------------
	// Key sequence states
	// ------------------------------------------------------------
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_GOT1 = 3'b010;
	localparam [2:0] ST_GOT2 = 3'b100;

	reg  [2:0]             state_r;
	reg  [2:0]             state_nxt;
	reg                    open_r;
	reg                    open_nxt;
	reg                    abort_nxt;
	reg  [31:0]            blk_addr_r;
	reg  [31:0]            blk_addr_nxt;
	reg  [31:0]            rdata_nxt;
	wire [31:0]            prot_mask;
	wire [31:0]            wr_allow;
	wire [7:0]             key_byte;
	wire                   hit_key;
	wire                   hit_cnt;
	wire                   hit_baddr;
	wire                   hit_own;
	wire                   wr_take;
	wire                   rd_take;
	wire                   blocked;
	wire [`RWL_CNT_W-1:0]  blk_cnt;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	assign hit_key   = (bus_addr == `RWL_ADDR_KEY);
	assign hit_cnt   = (bus_addr == `RWL_ADDR_BLK_CNT);
	assign hit_baddr = (bus_addr == `RWL_ADDR_BLK_ADDR);
	assign hit_own   = hit_key | hit_cnt | hit_baddr;
	assign wr_take   = bus_wr & ce;
	assign rd_take   = bus_rd & ce;
	assign key_byte  = bus_wdata[7:0]; // RULE7

	assign protect_disabled_flag = open_r; // RULE4

	// ------------------------------------------------------------
	// Guarded bit lookup
	// ------------------------------------------------------------
	rwl_prot_map u_prot_map
	(
		.addr      (bus_addr),
		.prot_mask (prot_mask)
	);

	// Each bit may be written unless it is guarded and the gate is shut
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi = gi + 1)
		begin : g_allow
			assign wr_allow[gi] = ~(prot_mask[gi] & ~open_r); // RULE8
		end
	endgenerate

	// A write counts as blocked when at least one bit was withheld
	assign blocked = wr_take & ~hit_own & ~(&wr_allow);

	// ------------------------------------------------------------
	// Key sequence and lock state
	// ------------------------------------------------------------
	always @*
	begin
		state_nxt = state_r;
		open_nxt  = open_r;
		abort_nxt = 1'b0;
		if (bus_wr)
		begin
			if (!hit_key)
			begin
				// Any other write breaks a sequence in progress
				if (state_r != ST_IDLE)
					abort_nxt = 1'b1; // RULE3
				state_nxt = ST_IDLE; // RULE3
			end
			else if (open_r)
			begin
				// Relock takes any value; the byte is not a key step
				open_nxt  = 1'b0; // RULE6
				state_nxt = ST_IDLE;
			end
			else
			begin
				case (state_r)
					ST_IDLE:
					begin
						if (key_byte == `RWL_KEY_FIRST) // RULE2
							state_nxt = ST_GOT1;
						else
							state_nxt = ST_IDLE;
					end
					ST_GOT1:
					begin
						if (key_byte == `RWL_KEY_SECOND) // RULE2
							state_nxt = ST_GOT2;
						else
						begin
							abort_nxt = 1'b1; // RULE3
							if (key_byte == `RWL_KEY_FIRST)
								state_nxt = ST_GOT1; // RULE17
							else
								state_nxt = ST_IDLE; // RULE17
						end
					end
					ST_GOT2:
					begin
						if (key_byte == `RWL_KEY_THIRD) // RULE2
						begin
							open_nxt  = 1'b1; // RULE4
							state_nxt = ST_IDLE;
						end
						else
						begin
							abort_nxt = 1'b1; // RULE3
							if (key_byte == `RWL_KEY_FIRST)
								state_nxt = ST_GOT1; // RULE17
							else
								state_nxt = ST_IDLE; // RULE17
						end
					end
					default:
					begin
						state_nxt = ST_IDLE;
					end
				endcase
			end
		end
	end

	always @(posedge core_clk)
	begin
		if (reset)
		begin
			state_r   <= ST_IDLE;
			open_r    <= 1'b0; // RULE1
			key_abort <= 1'b0;
		end
		else if (ce)
		begin
			state_r   <= state_nxt;
			open_r    <= open_nxt;
			key_abort <= abort_nxt;
		end
	end

	// ------------------------------------------------------------
	// Blocked write bookkeeping
	// ------------------------------------------------------------
	rwl_evt_cnt u_blk_cnt
	(
		.core_clk (core_clk),
		.reset    (reset),
		.ce       (ce),
		.evt      (blocked),
		.clr      (wr_take & hit_cnt),
		.count_r  (blk_cnt)
	);

	always @*
	begin
		blk_addr_nxt = blk_addr_r;
		if (wr_take && hit_baddr)
			blk_addr_nxt = 32'h0000_0000;
		// The latest blocked address wins over a software clear
		if (blocked)
			blk_addr_nxt = bus_addr;
	end

	always @(posedge core_clk)
	begin
		if (reset)
			blk_addr_r <= 32'h0000_0000;
		else if (ce)
			blk_addr_r <= blk_addr_nxt;
	end

	// ------------------------------------------------------------
	// Write forwarding to the system registers
	// ------------------------------------------------------------
	// Registered so the downstream file sees the mask and data together;
	// a fully withheld write is never presented at all.
	always @(posedge core_clk)
	begin
		if (reset)
		begin
			fwd_wr    <= 1'b0;
			fwd_addr  <= 32'h0000_0000;
			fwd_wdata <= 32'h0000_0000;
			fwd_wmask <= 32'h0000_0000;
		end
		else if (ce)
		begin
			fwd_wr <= bus_wr & ~hit_own & (|wr_allow); // RULE8
			if (bus_wr && !hit_own)
			begin
				fwd_addr  <= bus_addr;
				fwd_wdata <= bus_wdata;
				fwd_wmask <= wr_allow; // RULE8
			end
		end
	end

	// Reads of other addresses go on unchanged
	always @(posedge core_clk)
	begin
		if (reset)
		begin
			fwd_rd    <= 1'b0;
			fwd_raddr <= 32'h0000_0000;
		end
		else if (ce)
		begin
			fwd_rd <= bus_rd & ~hit_own;
			if (bus_rd && !hit_own)
				fwd_raddr <= bus_addr;
		end
	end

	// ------------------------------------------------------------
	// Read back of own registers
	// ------------------------------------------------------------
	always @*
	begin
		rdata_nxt = 32'h0000_0000;
		if (bus_rd)
		begin
			if (hit_key)
				rdata_nxt[`RWL_FLAG_BIT] = open_r; // RULE5 RULE7
			else if (hit_cnt)
				rdata_nxt[`RWL_CNT_W-1:0] = blk_cnt;
			else if (hit_baddr)
				rdata_nxt = blk_addr_r;
		end
	end

	// Data stand for one cycle only, zero otherwise
	always @(posedge core_clk)
	begin
		if (reset)
			bus_rdata <= `RWL_KEY_RESET;
		else if (ce)
			bus_rdata <= rdata_nxt;
	end

endmodule // rwl_top
`default_nettype wire

/* inc/rwl_defines.vh */
// Address map, key bytes and protection masks of the register write lock
`ifndef RWL_DEFINES_VH
`define RWL_DEFINES_VH

// ----------------------------------------------------------------
// Lock control and own status registers
// ----------------------------------------------------------------
`define RWL_ADDR_KEY        32'h5000_0100
`define RWL_ADDR_BLK_CNT    32'h5000_0104
`define RWL_ADDR_BLK_ADDR   32'h5000_0108
`define RWL_KEY_RESET       32'h0000_0000
`define RWL_FLAG_BIT        0
`define RWL_CNT_W           16
`define RWL_CNT_MAX         16'hFFFF

// ----------------------------------------------------------------
// Unlock key bytes, in order
// ----------------------------------------------------------------
`define RWL_KEY_FIRST       8'h59
`define RWL_KEY_SECOND      8'h16
`define RWL_KEY_THIRD       8'h88

// ----------------------------------------------------------------
// Guarded registers
// ----------------------------------------------------------------
`define RWL_ADDR_PRST1      32'h5000_0008
`define RWL_ADDR_BOD        32'h5000_0018
`define RWL_ADDR_POR        32'h5000_0024
`define RWL_ADDR_PWR        32'h5000_0200
`define RWL_ADDR_PCLK       32'h5000_0208
`define RWL_ADDR_CSEL0      32'h5000_0210
`define RWL_ADDR_CSEL1      32'h5000_0214
`define RWL_ADDR_NMI        32'h5000_0380
`define RWL_ADDR_FPCTL      32'h5000_C000
`define RWL_ADDR_FPTRG      32'h5000_C010
`define RWL_ADDR_FATC       32'h5000_C018
`define RWL_ADDR_WDT        32'h4000_4000

// ----------------------------------------------------------------
// Guarded bits per register (1 = guarded)
// ----------------------------------------------------------------
`define RWL_MASK_ALL        32'hFFFF_FFFF
`define RWL_MASK_NONE       32'h0000_0000
`define RWL_MASK_PWR        32'hFFFF_FFBF
`define RWL_MASK_PCLK       32'h0000_0001
`define RWL_MASK_CSEL1      32'h0000_0003
`define RWL_MASK_NMI        32'h0000_0100

`endif

/* logic/rwl_prot_map.v */
// Address to guarded-bit mask lookup for the register write lock
`timescale 1ns/10ps
`default_nettype none
`include "rwl_defines.vh"

module rwl_prot_map
(
	input  wire [31:0] addr,
	output reg  [31:0] prot_mask
);

	always @*
	begin
		case (addr)
			`RWL_ADDR_PRST1 : prot_mask = `RWL_MASK_ALL;   // RULE9
			`RWL_ADDR_BOD   : prot_mask = `RWL_MASK_ALL;   // RULE9
			`RWL_ADDR_POR   : prot_mask = `RWL_MASK_ALL;   // RULE9
			`RWL_ADDR_PWR   : prot_mask = `RWL_MASK_PWR;   // RULE10
			`RWL_ADDR_PCLK  : prot_mask = `RWL_MASK_PCLK;  // RULE11
			`RWL_ADDR_CSEL0 : prot_mask = `RWL_MASK_ALL;   // RULE12
			`RWL_ADDR_CSEL1 : prot_mask = `RWL_MASK_CSEL1; // RULE13
			`RWL_ADDR_NMI   : prot_mask = `RWL_MASK_NMI;   // RULE14
			`RWL_ADDR_FPCTL : prot_mask = `RWL_MASK_ALL;   // RULE15
			`RWL_ADDR_FPTRG : prot_mask = `RWL_MASK_ALL;   // RULE15
			`RWL_ADDR_FATC  : prot_mask = `RWL_MASK_ALL;   // RULE15
			`RWL_ADDR_WDT   : prot_mask = `RWL_MASK_ALL;   // RULE16
			default         : prot_mask = `RWL_MASK_NONE;
		endcase
	end

endmodule // rwl_prot_map
`default_nettype wire

/* logic/rwl_evt_cnt.v */
// Saturating event counter with software clear for the write lock
`timescale 1ns/10ps
`default_nettype none
`include "rwl_defines.vh"

module rwl_evt_cnt
(
	input  wire                    core_clk,
	input  wire                    reset,
	input  wire                    ce,
	input  wire                    evt,
	input  wire                    clr,
	output reg  [`RWL_CNT_W-1:0]   count_r
);

	reg [`RWL_CNT_W-1:0] count_nxt;

	always @*
	begin
		count_nxt = count_r;
		if (clr)
			count_nxt = {`RWL_CNT_W{1'b0}};
		// An event in the clearing cycle is kept, counted as the first
		if (evt && clr)
			count_nxt = {{(`RWL_CNT_W-1){1'b0}}, 1'b1};
		else if (evt && count_r != `RWL_CNT_MAX)
			count_nxt = count_r + {{(`RWL_CNT_W-1){1'b0}}, 1'b1};
	end

	always @(posedge core_clk)
	begin
		if (reset)
			count_r <= {`RWL_CNT_W{1'b0}};
		else if (ce)
			count_r <= count_nxt;
	end

endmodule // rwl_evt_cnt
`default_nettype wire

/* bench/rwl_props.sv */
// Concurrent checks on the ports of the register write lock
`timescale 1ns/10ps
`default_nettype none
`include "rwl_defines.vh"
module rwl_props
(
	input wire logic        core_clk,
	input wire logic        reset,
	input wire logic        ce,
	input wire logic [31:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	input wire logic        bus_wr,
	input wire logic        bus_rd,
	input wire logic [31:0] bus_rdata,
	input wire logic        fwd_wr,
	input wire logic [31:0] fwd_wmask,
	input wire logic        protect_disabled_flag,
	input wire logic        key_abort
);
	wire       pf = protect_disabled_flag;
	wire       w  = ce && bus_wr;
	wire       kw = w && bus_addr == `RWL_ADDR_KEY;
	wire [7:0] kb = bus_wdata[7:0];
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	property p_locked; $fell(reset) |-> !pf; endproperty
	property p_unlock;
		!pf && kw && kb == 8'h59 ##1 kw && kb == 8'h16
			##1 kw && kb == 8'h88 |=> pf;
	endproperty
	property p_abort;
		!pf && kw && kb == 8'h59 ##1 kw && kb != 8'h16 |=> key_abort && !pf;
	endproperty
	property p_relock; pf && kw |=> !pf; endproperty
	property p_read;
		ce && bus_rd && bus_addr == `RWL_ADDR_KEY
			|=> bus_rdata == {31'h0000_0000, $past(pf)};
	endproperty
	property p_guard; !pf && w && bus_addr == `RWL_ADDR_PRST1 |=> !fwd_wr;
	endproperty
	property p_pwr;
		!pf && w && bus_addr == `RWL_ADDR_PWR
			|=> fwd_wr && fwd_wmask == 32'h0000_0040;
	endproperty
	property p_open;
		pf && w && bus_addr == `RWL_ADDR_WDT
			|=> fwd_wr && fwd_wmask == 32'hFFFF_FFFF;
	endproperty
	a_locked: assert property (p_locked) else $error("unlocked at reset");
	a_unlock: assert property (p_unlock) else $error("key ignored");
	a_abort: assert property (p_abort) else $error("no abort");
	a_relock: assert property (p_relock) else $error("no relock");
	a_read: assert property (p_read) else $error("bad flag read");
	a_guard: assert property (p_guard) else $error("guarded passed");
	a_pwr: assert property (p_pwr) else $error("bad power mask");
	a_open: assert property (p_open) else $error("open write cut");
	c_open: cover property ($rose(pf));
	c_shut: cover property ($fell(pf));
	c_abort: cover property (key_abort);
endmodule // rwl_props
bind rwl_top rwl_props rwl_props_inst (.core_clk(core_clk), .reset(reset),
	.ce(ce), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
	.bus_rd(bus_rd), .bus_rdata(bus_rdata), .fwd_wr(fwd_wr),
	.fwd_wmask(fwd_wmask), .protect_disabled_flag(protect_disabled_flag),
	.key_abort(key_abort));
`default_nettype wire

/* bench/rwl_sys_regs.sv */
// Behavioural store of the system registers behind the write gate
`timescale 1ns/10ps
`default_nettype none
module rwl_sys_regs
(
	input wire logic        core_clk,
	input wire logic        fwd_wr,
	input wire logic [31:0] fwd_addr,
	input wire logic [31:0] fwd_wdata,
	input wire logic [31:0] fwd_wmask
);
	logic [31:0] mem [logic [31:0]];
	function automatic logic [31:0] peek(input logic [31:0] a);
		return mem.exists(a) ? mem[a] : 32'h0000_0000;
	endfunction
	// Bits outside the mask keep their old value
	always @(posedge core_clk)
		if (fwd_wr === 1'b1)
			mem[fwd_addr] = (peek(fwd_addr) & ~fwd_wmask) | (fwd_wdata & fwd_wmask);
endmodule // rwl_sys_regs
`default_nettype wire

/* bench/test_register_write_lock.sv */
// Self-checking bench of the register write lock
`timescale 1ns/10ps
`default_nettype none
`include "rwl_defines.vh"
module test_register_write_lock;
	logic        core_clk  = 1'b0;
	logic        reset     = 1'b1;
	logic        ce        = 1'b1;
	logic [31:0] bus_addr  = 32'h0000_0000;
	logic [31:0] bus_wdata = 32'h0000_0000;
	logic        bus_wr    = 1'b0;
	logic        bus_rd    = 1'b0;
	wire  [31:0] bus_rdata, fwd_addr, fwd_wdata, fwd_wmask, fwd_raddr;
	wire         fwd_wr, fwd_rd, flag, key_abort;
	int          err_total = 0;
	int          checks    = 0;
	logic [31:0] rnd       = 32'h0000_004B;
	// Bench copy of what each guarded register should hold
	logic [31:0] shadow [12] = '{default: 32'h0000_0000};
	localparam logic [31:0] ga [12] = '{`RWL_ADDR_PRST1, `RWL_ADDR_BOD,
		`RWL_ADDR_POR, `RWL_ADDR_PWR, `RWL_ADDR_PCLK, `RWL_ADDR_CSEL0,
		`RWL_ADDR_CSEL1, `RWL_ADDR_NMI, `RWL_ADDR_FPCTL, `RWL_ADDR_FPTRG,
		`RWL_ADDR_FATC, `RWL_ADDR_WDT};
	always #20 core_clk = ~core_clk;
	rwl_top rwl_top_inst (.core_clk(core_clk), .reset(reset), .ce(ce),
		.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .bus_rdata(bus_rdata), .fwd_wr(fwd_wr),
		.fwd_addr(fwd_addr), .fwd_wdata(fwd_wdata), .fwd_wmask(fwd_wmask),
		.fwd_rd(fwd_rd), .fwd_raddr(fwd_raddr),
		.protect_disabled_flag(flag), .key_abort(key_abort));
	rwl_sys_regs rwl_sys_regs_inst (.core_clk(core_clk), .fwd_wr(fwd_wr),
		.fwd_addr(fwd_addr), .fwd_wdata(fwd_wdata), .fwd_wmask(fwd_wmask));
	function automatic logic [31:0] nxt(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	function automatic logic [31:0] gm(input logic [31:0] a);
		case (a)
			`RWL_ADDR_PWR: return 32'hFFFF_FFBF;
			`RWL_ADDR_PCLK: return 32'h0000_0001;
			`RWL_ADDR_CSEL1: return 32'h0000_0003;
			`RWL_ADDR_NMI: return 32'h0000_0100;
			default: return 32'hFFFF_FFFF;
		endcase
	endfunction
	task automatic chk(input string n, input logic [31:0] s, e);
		checks++;
		if (s !== e)
		begin
			err_total++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [31:0] a, v);
		bus_addr <= a;
		bus_wdata <= v;
		bus_wr <= 1'b1;
		bus_rd <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rd(input string n, input logic [31:0] a, e);
		bus_addr <= a;
		bus_wr <= 1'b0;
		bus_rd <= 1'b1;
		@(posedge core_clk);
		bus_rd <= 1'b0;
		#1;
		chk(n, bus_rdata, e);
	endtask
	// Key bytes come from the top byte down; upper data bits are noise
	task automatic kseq(input int n, input logic [31:0] b);
		for (int k = 0; k < n; k++)
		begin
			rnd = nxt(rnd);
			wr(`RWL_ADDR_KEY, {rnd[31:8], b[31-8*k -: 8]});
		end
	endtask
	task automatic sweep(input logic open);
		logic [31:0] ex;
		for (int i = 0; i < 12; i++)
		begin
			rnd = nxt(rnd);
			ex = open ? rnd : (shadow[i] & gm(ga[i])) | (rnd & ~gm(ga[i]));
			shadow[i] = ex;
			wr(ga[i], rnd);
			bus_wr <= 1'b0;
			repeat (2) @(posedge core_clk);
			chk("store", rwl_sys_regs_inst.peek(ga[i]), ex);
		end
		$display("sweep done, open %0d", open);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		rd("flag", `RWL_ADDR_KEY, 32'h0000_0000);
		rd("spare", 32'h5000_0110, 32'h0000_0000);
		chk("fwd_rd", {31'h0, fwd_rd}, 32'h0000_0001);
		chk("fwd_raddr", fwd_raddr, 32'h5000_0110);
		sweep(1'b0);
		chk("fwd_addr", fwd_addr, `RWL_ADDR_WDT);
		chk("fwd_wdata", fwd_wdata, rnd);
		rd("blocked", `RWL_ADDR_BLK_CNT, 32'h0000_000C);
		rd("blkaddr", `RWL_ADDR_BLK_ADDR, `RWL_ADDR_WDT);
		wr(`RWL_ADDR_BLK_CNT, rnd);
		rd("cleared", `RWL_ADDR_BLK_CNT, 32'h0000_0000);
		kseq(3, 32'h5916_8900);
		rd("flag", `RWL_ADDR_KEY, 32'h0000_0000);
		kseq(4, 32'h5988_1688);
		rd("flag", `RWL_ADDR_KEY, 32'h0000_0000);
		kseq(1, 32'h5900_0000);
		wr(`RWL_ADDR_PCLK, rnd);
		kseq(2, 32'h1688_0000);
		rd("flag", `RWL_ADDR_KEY, 32'h0000_0000);
		$display("abort tests done");
		kseq(4, 32'h5959_1688);
		rd("flag", `RWL_ADDR_KEY, 32'h0000_0001);
		sweep(1'b1);
		kseq(3, 32'h5916_8800);
		rd("flag", `RWL_ADDR_KEY, 32'h0000_0000);
		rd("flag", `RWL_ADDR_KEY, 32'h0000_0000);
		// Key writes while the enable is low must leave the gate shut
		ce <= 1'b0;
		kseq(3, 32'h5916_8800);
		ce <= 1'b1;
		bus_wr <= 1'b0;
		@(posedge core_clk);
		rd("frozen", `RWL_ADDR_KEY, 32'h0000_0000);
		$display("enable test done");
		sweep(1'b0);
		test_done;
	end
	initial
	begin
		repeat (3000) @(posedge core_clk);
		err_total++;
		test_done;
	end
endmodule // test_register_write_lock
`default_nettype wire
